// file: common/sio_pkg.sv
// Purpose: shared constants and types of the servo I/O function allocator
// Assumes: 32-bit classic Wishbone register bus, byte addressed
// Notes: function codes carry contact logic in bit 7
package sio_pkg;

  localparam int SIO_IN_PINS = 8;
  localparam int SIO_OUT_PINS = 2;
  localparam int SIO_IN_FUNCS = 12;
  localparam int SIO_ADR_W = 6;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] SIO_OFS_IN_SEL_FIRST = 6'h00;
  localparam logic [5:0] SIO_OFS_IN_SEL_LAST = 6'h1C;
  localparam logic [5:0] SIO_OFS_OUT_SEL_FIRST = 6'h20;
  localparam logic [5:0] SIO_OFS_OUT_SEL_SECOND = 6'h24;
  localparam logic [5:0] SIO_OFS_MODE = 6'h28;
  localparam logic [5:0] SIO_OFS_ALARM = 6'h2C;
  localparam logic [5:0] SIO_OFS_LEVELS = 6'h30;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0][31:0] SIO_IN_SEL_RESET = {
    32'h002E2E2E, 32'h00202020, 32'h00212121, 32'h002B2B2B,
    32'h00222222, 32'h00828282, 32'h00818181, 32'h00949494};
  localparam logic [1:0][31:0] SIO_OUT_SEL_RESET = {
    32'h00020202, 32'h00030303};

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SIO_NC_BIT = 7;
  localparam int SIO_LEVELS_FUNC_LSB = 8;
  localparam int SIO_LEVELS_OUT_LSB = 24;
  localparam int SIO_LATCH_PIN_LO = 4;
  localparam int SIO_LATCH_PIN_HI = 6;

  // alarm status bit positions
  localparam int SIO_ALM_DUP = 0;
  localparam int SIO_ALM_PIN_MISMATCH = 1;
  localparam int SIO_ALM_LOGIC = 2;
  localparam int SIO_ALM_BRAKE = 3;
  localparam int SIO_ALM_LATCH = 4;
  localparam int SIO_ALM_W = 5;

  // ---------------------------------------------------------------
  // function codes (normally-open form)
  // ---------------------------------------------------------------
  localparam logic [7:0] SIO_CODE_DISABLED = 8'h00;
  localparam logic [7:0] SIO_CODE_FWD_PROHIBIT = 8'h01;
  localparam logic [7:0] SIO_CODE_REV_PROHIBIT = 8'h02;
  localparam logic [7:0] SIO_CODE_ESTOP = 8'h14;
  localparam logic [7:0] SIO_CODE_LATCH_ONE = 8'h20;
  localparam logic [7:0] SIO_CODE_LATCH_TWO = 8'h21;
  localparam logic [7:0] SIO_CODE_ORIGIN = 8'h22;
  localparam logic [7:0] SIO_CODE_LATCH_THREE = 8'h2B;
  localparam logic [7:0] SIO_CODE_FWD_CLAMP = 8'h2C;
  localparam logic [7:0] SIO_CODE_REV_CLAMP = 8'h2D;
  localparam logic [7:0] SIO_CODE_MON_ZERO = 8'h2E;
  localparam logic [7:0] SIO_CODE_MON_ONE = 8'h2F;
  localparam logic [7:0] SIO_CODE_MON_TWO = 8'h30;
  localparam logic [7:0] SIO_OUT_CODE_MIN = 8'h02;
  localparam logic [7:0] SIO_OUT_CODE_MAX = 8'h0F;
  localparam logic [7:0] SIO_OUT_CODE_BRAKE = 8'h03;

  typedef enum logic [1:0] {
    SIO_MODE_POSITION,
    SIO_MODE_SPEED,
    SIO_MODE_TORQUE
  } sio_mode_t;

endpackage

// file: hw/sio_allocator.sv
// Purpose: maps eight control inputs and two outputs onto drive functions
// Assumes: classic Wishbone slave, pins synchronous to clk
// Notes: alarm status is live, recomputed from the selections every cycle
//
// Contract
// R1 - each input selector holds per-mode function codes
// R2 - byte0 position, byte1 speed, byte2 torque
// R3 - input codes embed logic; bit7 means NC
// R4 - latch codes 20h,21h,2Bh normally-open only
// R5 - software writes only listed function codes
// R6 - same input function on two pins alarms
// R7 - latch functions only on pins five-seven
// R8 - latch in some but not all modes alarms
// R9 - disabled input pin has no effect
// R10 - shared function must keep same pin
// R11 - shared function logic mismatch alarms
// R12 - NO output on when active; NC inverted
// R13 - output selectors use same byte layout
// R14 - output codes 02h-0Fh, bit7 NC, 00h off
// R15 - same output function on both pins allowed
// R16 - disabled output pin keeps transistor off
// R17 - brake output missing in some mode alarms
// R18 - brake output code 03h normally-open only
// R19 - NO input active shorted; NC active open
// R20 - top selector byte ignored
module sio_allocator (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sio_pkg::SIO_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] input_shorted,
  output logic [11:0] in_function_active,
  input wire logic [15:0] out_function_state,
  output logic [1:0] output_transistor_on,
  output logic [4:0] config_alarm,
  output logic config_alarm_any
);
  import sio_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // every flop of the block lives in this one struct, so a reset
  // value exists for each of them and none can be left floating.
  // the selectors keep their defaults until software rewrites them;
  // the pin and alarm copies are refreshed on every clock edge.
  // alarms are recomputed rather than latched: a bad allocation
  // shows as long as it is configured and clears once it is fixed,
  // which trades a sticky record for having no clear path at all.
  typedef struct packed {
    logic [7:0][31:0] in_sel_reg;
    logic [1:0][31:0] out_sel_reg;
    logic [1:0] mode_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [SIO_ALM_W-1:0] alarm_reg;
    logic [11:0] in_func_reg;
    logic [1:0] out_on_reg;
  } sio_state_t;

  localparam sio_state_t SIO_STATE_RESET = '{
    in_sel_reg: SIO_IN_SEL_RESET,
    out_sel_reg: SIO_OUT_SEL_RESET,
    mode_reg: 2'h0,
    ack_reg: 1'b0,
    dat_reg: 32'h00000000,
    alarm_reg: '0,
    in_func_reg: 12'h000,
    out_on_reg: 2'h0
  };

  sio_state_t s_reg;
  sio_state_t s_next;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // sio_mode_byte and sio_in_index are used by both the check loop and the pin loop, so
  // the two can never disagree on what an input code means.
  // unlisted codes decode as slot zero and therefore behave exactly
  // like a disabled pin; software gets no error for them.
  // a latch code with the nc bit set has no listed meaning and is
  // likewise dropped to slot zero instead of raising an alarm.
  // picks the code of one mode; the top byte never reaches decode
  function automatic logic [7:0] sio_mode_byte(input logic [31:0] word,
                                               input logic [1:0] mode);
    case (mode)
      2'h1: sio_mode_byte = word[15:8]; // R2 R13 R20
      2'h2: sio_mode_byte = word[23:16];
      default: sio_mode_byte = word[7:0];
    endcase
  endfunction

  // input code to function slot 1..12, 0 when disabled or not listed
  function automatic logic [3:0] sio_in_index(input logic [7:0] code);
    logic nc;
    logic [7:0] base;
    nc = code[SIO_NC_BIT]; // R3
    base = {1'b0, code[6:0]};
    case (base)
      SIO_CODE_FWD_PROHIBIT: sio_in_index = 4'h1;
      SIO_CODE_REV_PROHIBIT: sio_in_index = 4'h2;
      SIO_CODE_ESTOP: sio_in_index = 4'h3;
      SIO_CODE_LATCH_ONE: sio_in_index = nc ? 4'h0 : 4'h4; // R4
      SIO_CODE_LATCH_TWO: sio_in_index = nc ? 4'h0 : 4'h5; // R4
      SIO_CODE_ORIGIN: sio_in_index = 4'h6;
      SIO_CODE_LATCH_THREE: sio_in_index = nc ? 4'h0 : 4'h7; // R4
      SIO_CODE_FWD_CLAMP: sio_in_index = 4'h8;
      SIO_CODE_REV_CLAMP: sio_in_index = 4'h9;
      SIO_CODE_MON_ZERO: sio_in_index = 4'hA;
      SIO_CODE_MON_ONE: sio_in_index = 4'hB;
      SIO_CODE_MON_TWO: sio_in_index = 4'hC;
      default: sio_in_index = 4'h0;
    endcase
  endfunction

  function automatic logic sio_is_latch(input logic [3:0] idx);
    sio_is_latch = (idx == 4'h4) || (idx == 4'h5) || (idx == 4'h7);
  endfunction

  // output code valid: 02h..0Fh in either logic, brake only as NO
  function automatic logic sio_out_valid(input logic [7:0] code);
    logic [7:0] base;
    base = {1'b0, code[6:0]};
    sio_out_valid = (base >= SIO_OUT_CODE_MIN) &&
                    (base <= SIO_OUT_CODE_MAX) &&
                    !(base == SIO_OUT_CODE_BRAKE &&
                      code[SIO_NC_BIT]); // R14 R18
  endfunction

  function automatic logic [31:0] sio_merge(input logic [31:0] old,
                                            input logic [31:0] wr,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wr[b*8 +: 8];
      end
    end
    sio_merge = r;
  endfunction

  // ---------------------------------------------------------------
  // allocation check and pin evaluation
  // ---------------------------------------------------------------
  // pin_mask records, per mode and per function slot, which pins
  // carry that function; comparing masks between modes finds a
  // shared function that moved, and a second bit within one mode
  // finds a duplicate.
  // nc_seen and no_seen gather the contact logic over all modes.
  // the whole check is one combinational cone over 30 selector
  // bytes; it is registered once so the alarm port stays glitch free
  // and lands one cycle after the selector itself.
  logic [2:0][12:0][7:0] pin_mask;
  logic [12:0] nc_seen;
  logic [12:0] no_seen;
  logic [12:0][2:0] mode_used;
  logic [2:0] brake_in_mode;
  logic [SIO_ALM_W-1:0] alarm_now;
  logic [11:0] func_now;
  logic [1:0] out_now;
  logic [1:0] act_mode;
  logic [7:0] code;
  logic [3:0] idx;

  always_comb begin
    pin_mask = '0;
    nc_seen = '0;
    no_seen = '0;
    mode_used = '0;
    brake_in_mode = 3'h0;
    alarm_now = '0;
    func_now = 12'h000;
    out_now = 2'h0;
    code = 8'h00;
    idx = 4'h0;
    // mode code 3 is not a mode; fall back to position control
    act_mode = (s_reg.mode_reg == 2'h3) ? 2'h0 : s_reg.mode_reg;

    for (int m = 0; m < 3; m++) begin
      for (int p = 0; p < SIO_IN_PINS; p++) begin
        code = sio_mode_byte(s_reg.in_sel_reg[p], m[1:0]); // R1
        idx = sio_in_index(code);
        if (idx != 4'h0) begin
          if (pin_mask[m][idx] != 8'h00) begin
            alarm_now[SIO_ALM_DUP] = 1'b1; // R6
          end
          pin_mask[m][idx][p] = 1'b1;
          mode_used[idx][m] = 1'b1;
          if (code[SIO_NC_BIT]) begin
            nc_seen[idx] = 1'b1;
          end else begin
            no_seen[idx] = 1'b1;
          end
          if (sio_is_latch(idx) &&
              (p < SIO_LATCH_PIN_LO || p > SIO_LATCH_PIN_HI)) begin
            alarm_now[SIO_ALM_LATCH] = 1'b1; // R7
          end
        end
      end
      for (int q = 0; q < SIO_OUT_PINS; q++) begin
        if (sio_mode_byte(s_reg.out_sel_reg[q], m[1:0]) ==
            SIO_OUT_CODE_BRAKE) begin
          brake_in_mode[m] = 1'b1;
        end
      end
    end

    for (int f = 1; f <= SIO_IN_FUNCS; f++) begin
      for (int a = 0; a < 3; a++) begin
        for (int b = a + 1; b < 3; b++) begin
          if (mode_used[f][a] && mode_used[f][b] &&
              pin_mask[a][f] != pin_mask[b][f]) begin
            alarm_now[SIO_ALM_PIN_MISMATCH] = 1'b1; // R10
          end
        end
      end
      if (nc_seen[f] && no_seen[f]) begin
        alarm_now[SIO_ALM_LOGIC] = 1'b1; // R11
      end
      if (sio_is_latch(f[3:0]) && mode_used[f] != 3'h0 &&
          mode_used[f] != 3'h7) begin
        alarm_now[SIO_ALM_LATCH] = 1'b1; // R8
      end
    end

    if (brake_in_mode != 3'h0 && brake_in_mode != 3'h7) begin
      alarm_now[SIO_ALM_BRAKE] = 1'b1; // R17
    end

    // input functions for the active mode; unlisted codes act as disabled
    for (int p = 0; p < SIO_IN_PINS; p++) begin
      code = sio_mode_byte(s_reg.in_sel_reg[p], act_mode);
      idx = sio_in_index(code);
      if (idx != 4'h0) begin // R9
        // shorted reads active for NO, open reads active for NC
        func_now[idx - 4'h1] = func_now[idx - 4'h1] |
          (input_shorted[p] ^ code[SIO_NC_BIT]); // R19
      end
    end

    // both pins may carry one function; each decodes on its own
    for (int q = 0; q < SIO_OUT_PINS; q++) begin // R15
      code = sio_mode_byte(s_reg.out_sel_reg[q], act_mode);
      if (sio_out_valid(code)) begin
        out_now[q] = out_function_state[code[3:0]] ^
                     code[SIO_NC_BIT]; // R12
      end else begin
        out_now[q] = 1'b0; // R16
      end
    end
  end

  // ---------------------------------------------------------------
  // register bus and next state
  // ---------------------------------------------------------------
  // a request is taken only while ack is low, so a master that keeps
  // stb up after ack is served again one cycle later, never twice
  // in the same cycle.
  // writes land on the taking edge; read data is captured there too
  // and holds until the next read, while ack stands for exactly one cycle.
  // alarm and level words are read only: writes to them are acked
  // and dropped so a stray write cannot mask a live alarm.
  logic req;
  logic [3:0] word;

  always_comb begin
    s_next = s_reg;
    req = wb_cyc_i && wb_stb_i && !s_reg.ack_reg;
    word = wb_adr_i[5:2];
    s_next.ack_reg = req;
    s_next.alarm_reg = alarm_now;
    s_next.in_func_reg = func_now;
    s_next.out_on_reg = out_now;
    if (req && wb_we_i) begin
      // software is trusted to write listed codes only
      if (wb_adr_i <= SIO_OFS_IN_SEL_LAST) begin // R5
        s_next.in_sel_reg[word[2:0]] = sio_merge(
          s_reg.in_sel_reg[word[2:0]], wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == SIO_OFS_OUT_SEL_FIRST ||
                   wb_adr_i == SIO_OFS_OUT_SEL_SECOND) begin
        s_next.out_sel_reg[word[0]] = sio_merge(
          s_reg.out_sel_reg[word[0]], wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == SIO_OFS_MODE && wb_sel_i[0]) begin
        s_next.mode_reg = wb_dat_i[1:0];
      end
    end
    if (req && !wb_we_i) begin
      if (wb_adr_i <= SIO_OFS_IN_SEL_LAST) begin
        s_next.dat_reg = s_reg.in_sel_reg[word[2:0]];
      end else if (wb_adr_i == SIO_OFS_OUT_SEL_FIRST ||
                   wb_adr_i == SIO_OFS_OUT_SEL_SECOND) begin
        s_next.dat_reg = s_reg.out_sel_reg[word[0]];
      end else if (wb_adr_i == SIO_OFS_MODE) begin
        s_next.dat_reg = {30'h00000000, s_reg.mode_reg};
      end else if (wb_adr_i == SIO_OFS_ALARM) begin
        s_next.dat_reg = {27'h0000000, s_reg.alarm_reg};
      end else if (wb_adr_i == SIO_OFS_LEVELS) begin
        s_next.dat_reg = {6'h00, s_reg.out_on_reg,
                          4'h0, s_reg.in_func_reg, input_shorted};
      end else begin
        // unmapped: acknowledged, reads zero, writes dropped
        s_next.dat_reg = 32'h00000000;
      end
    end
    // unaligned low address bits fall through the decode above
    if (req && wb_adr_i[1:0] != 2'h0 && !wb_we_i) begin
      s_next.dat_reg = 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= SIO_STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // every output but the summary is a plain flop copy; the summary is
  // an or over flops, so it settles in the same cycle as the flags.
  // transistor outputs default off through reset, which keeps a
  // brake released by a normally-closed wiring from moving early.
  assign wb_ack_o = s_reg.ack_reg;
  assign wb_dat_o = s_reg.dat_reg;
  assign in_function_active = s_reg.in_func_reg;
  assign output_transistor_on = s_reg.out_on_reg;
  assign config_alarm = s_reg.alarm_reg;
  assign config_alarm_any = |s_reg.alarm_reg;

endmodule

// file: testbench/sio_allocator_chk.sv
// Purpose: port-level checks of the servo I/O allocator
// Assumes: one clock, reset_n asynchronous active low
// Notes: selectors are not shadowed; outputs are tied to their causes
module sio_allocator_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sio_pkg::SIO_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] input_shorted,
  input wire logic [11:0] in_function_active,
  input wire logic [15:0] out_function_state,
  input wire logic [1:0] output_transistor_on,
  input wire logic [4:0] config_alarm,
  input wire logic config_alarm_any
);
  timeunit 1ns;
  timeprecision 1ps;
  import sio_pkg::*;
  logic take;
  logic wr_take;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_take = take && wb_we_i;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  sequence s_ack_pulse;
    ##1 wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_rd(logic [5:0] a);
    take && !wb_we_i && wb_adr_i == a ##1 wb_ack_o;
  endsequence
  a_ack_answer: assert property (take |-> s_ack_pulse)
    else $error("ack missing or longer than one cycle");
  a_ack_idle: assert property (!take |=> !wb_ack_o)
    else $error("ack without a request");
  a_levels_read: assert property (s_rd(SIO_OFS_LEVELS) |->
    wb_dat_o[19:0] == {$past(in_function_active), $past(input_shorted)}
    && wb_dat_o[25:24] == $past(output_transistor_on))
    else $error("levels word differs from pin state");
  a_alarm_read: assert property (s_rd(SIO_OFS_ALARM) |->
    wb_dat_o[4:0] == $past(config_alarm))
    else $error("alarm word differs from alarm port");
  a_alarm_cause: assert property ($changed(config_alarm) |->
    $past(wr_take, 2) || !$past(reset_n, 2))
    else $error("alarm moved without a write");
  // mapping is frozen between writes, so pins alone move the functions
  a_in_cause: assert property ($changed(in_function_active) |->
    $past(wr_take, 2) || !$past(reset_n, 2)
    || $past(input_shorted) != $past(input_shorted, 2))
    else $error("input function moved without cause");
  a_out_cause: assert property ($changed(output_transistor_on) |->
    $past(wr_take, 2) || !$past(reset_n, 2)
    || $past(out_function_state) != $past(out_function_state, 2))
    else $error("transistor moved without cause");
  a_alarm_any: assert property (config_alarm_any == (|config_alarm))
    else $error("summary alarm differs from flags");
endmodule
bind sio_allocator sio_allocator_chk u_chk (.clk, .reset_n, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .input_shorted, .in_function_active, .out_function_state,
  .output_transistor_on, .config_alarm, .config_alarm_any);

// file: testbench/sio_field.sv
// Purpose: field contacts wired to the drive's control inputs
// Assumes: contacts change between clock edges
// Notes: no bounce; a closed contact shorts the pin to common
module sio_field (
  input wire logic clk,
  input wire logic [7:0] switch_closed,
  output logic [7:0] input_shorted
);
  timeunit 1ns;
  timeprecision 1ps;
  import sio_pkg::*;
  initial input_shorted = 8'h00;
  // one cycle of wiring delay keeps stimulus away from the sampling edge
  always @(posedge clk) begin
    input_shorted <= switch_closed;
  end
endmodule

// file: testbench/tb.sv
// Purpose: self-checking bench of the servo I/O allocator
// Assumes: 20 MHz clock, classic Wishbone single cycles
// Notes: expectations come from the function code tables
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sio_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] switch_closed = 8'h00;
  logic [7:0] input_shorted;
  logic [11:0] in_function_active;
  logic [15:0] out_function_state = 16'h0000;
  logic [1:0] output_transistor_on;
  logic [4:0] config_alarm;
  logic config_alarm_any;
  logic [31:0] rd;
  int fail_count = 0;
  int n_tests = 0;
  logic [5:0] a1 [9] = '{6'h1C, 6'h10, 6'h10, 6'h0C, 6'h0C, 6'h20, 6'h20,
    6'h24, 6'h10};
  logic [31:0] d1 [9] = '{32'h00949494, 32'h0, 32'h002B2B00, 32'h00000022,
    32'h0022A222, 32'h00030300, 32'h00838383, 32'h00030303, 32'h00ABABAB};
  logic [5:0] a2 [9] = '{6'h34, 6'h1C, 6'h34, 6'h1C, 6'h34, 6'h34, 6'h34,
    6'h34, 6'h34};
  logic [31:0] d2 [9] = '{32'h0, 32'h002B2B2B, 32'h0, 32'h00222E2E, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0};
  logic [4:0] ea [9] = '{5'h01, 5'h10, 5'h10, 5'h02, 5'h04, 5'h08, 5'h00,
    5'h00, 5'h00};
  always #25 clk = ~clk;
  sio_field u_field (.clk, .switch_closed, .input_shorted);
  sio_allocator dut (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .input_shorted,
    .in_function_active, .out_function_state, .output_transistor_on,
    .config_alarm, .config_alarm_any);
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [5:0] a,
    input logic [31:0] d);
    int k;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    if (k == 20) begin
      fail_count++;
      results;
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic restore;
    for (int p = 0; p < 8; p++) bus(1'b1, 6'(4 * p), SIO_IN_SEL_RESET[p]);
    bus(1'b1, SIO_OFS_OUT_SEL_FIRST, SIO_OUT_SEL_RESET[0]);
    bus(1'b1, SIO_OFS_OUT_SEL_SECOND, SIO_OUT_SEL_RESET[1]);
    bus(1'b1, SIO_OFS_MODE, 32'h0);
    settle;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    bus(1'b1, SIO_OFS_ALARM, 32'hFFFFFFFF);
    bus(1'b1, 6'h34, 32'hFFFFFFFF);
    for (int p = 0; p < 10; p++) begin
      bus(1'b0, 6'(4 * p), 32'h0);
      check(rd, p < 8 ? SIO_IN_SEL_RESET[p] : SIO_OUT_SEL_RESET[p - 8]);
    end
    bus(1'b0, SIO_OFS_ALARM, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 6'h34, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_inputs;
    settle;
    check(32'(in_function_active), 32'h007);
    @(posedge clk);
    switch_closed <= 8'hFF;
    settle;
    check(32'(in_function_active), 32'h278);
    bus(1'b0, SIO_OFS_LEVELS, 32'h0);
    check(rd, 32'h000278FF);
    $display("test inputs done");
  endtask
  task automatic t_modes;
    logic [11:0] em [4] = '{12'h278, 12'h078, 12'h0F8, 12'h278};
    bus(1'b1, SIO_OFS_IN_SEL_LAST, 32'hFF2C002E);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, SIO_OFS_MODE, 32'(m));
      settle;
      check(32'(in_function_active), 32'(em[m]));
    end
    check(32'(config_alarm), 32'h0);
    restore;
    $display("test modes done");
  endtask
  task automatic t_alarms;
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, a1[i], d1[i]);
      bus(1'b1, a2[i], d2[i]);
      settle;
      check(32'(config_alarm), 32'(ea[i]));
      check(32'(config_alarm_any), 32'(|ea[i]));
      if (i == 8) check(32'(in_function_active), 32'h238);
      restore;
    end
    $display("test alarms done");
  endtask
  task automatic t_outputs;
    logic e;
    bus(1'b1, SIO_OFS_OUT_SEL_SECOND, 32'h0);
    for (int c = 2; c < 16; c++) begin
      for (int n = 0; n < 2; n++) begin
        bus(1'b1, SIO_OFS_OUT_SEL_FIRST, {24'h0, 1'(n), 7'(c)});
        for (int s = 0; s < 2; s++) begin
          @(posedge clk);
          out_function_state <= 16'(s) << c;
          settle;
          e = (c == 3 && n == 1) ? 1'b0 : 1'(s ^ n);
          check(32'(output_transistor_on), {31'h0, e});
        end
      end
    end
    $display("test outputs done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_inputs;
    t_modes;
    t_alarms;
    t_outputs;
    results;
  end
  initial begin
    #(50 * 20000);
    fail_count++;
    results;
  end
endmodule
